/* File: verilog/fpf_pkg.sv */
/*
  fpf_pkg: shared constants, format codes and decode helpers for the
  floating-point load/store format converter.
  Assumes: 64-bit floating registers, 32-bit formats in the low half of
  the memory word.
*/
package fpf_pkg;

  localparam int DATA_W = 64;
  localparam int EXP_W = 11;
  localparam int TEXP_W = 12;
  localparam int CAUSE_W = 7;
  localparam int TRAP_W = 5;

  // register-format field positions
  localparam int SIGN_POS = 63;
  localparam int EXP_MSB = 62;
  localparam int EXP_LSB = 52;
  localparam int FRAC_MSB = 51;
  localparam int QUIET_POS = 51;
  localparam int D_EXP_LSB = 55;
  localparam int S_FRAC_LSB = 29;

  // exponent codes and biases
  localparam logic [10:0] EXP_ONES = 11'h7FF;
  localparam logic [7:0] EXPN_ONES = 8'hFF;
  localparam logic [10:0] F_ONES_MAP = 11'h47F;
  localparam logic [2:0] WIDEN_HI = 3'h0;
  localparam logic [2:0] WIDEN_LO = 3'h7;
  localparam logic [11:0] G_BIAS = 12'h400;
  localparam logic [11:0] D_BIAS = 12'h080;
  localparam logic [11:0] T_BIAS = 12'h3FF;
  localparam logic [11:0] S_DEN_EXP = 12'hF82;
  localparam logic [11:0] T_DEN_EXP = 12'hC02;
  localparam logic [63:0] ZERO64 = 64'h0000_0000_0000_0000;

  // exception cause bit positions; trap input uses the low five
  localparam int CS_INEXACT = 0;
  localparam int CS_DIVZERO = 1;
  localparam int CS_UNDER = 2;
  localparam int CS_OVER = 3;
  localparam int CS_INVALID = 4;
  localparam int CS_NO_ARITH = 5;
  localparam int CS_RESERVED = 6;

  typedef enum logic [4:0] {
    FMT_F = 5'h01,
    FMT_G = 5'h02,
    FMT_D = 5'h04,
    FMT_S = 5'h08,
    FMT_T = 5'h10
  } fpf_fmt_t;

  function automatic logic isLegacy(input fpf_fmt_t f);
    isLegacy = (f == FMT_F) || (f == FMT_G) || (f == FMT_D);
  endfunction

endpackage

/* File: verilog/fpf_layout_conv.sv */
/*
  fpf_layout_conv: combinational memory/register layout conversion for
  load and store of every supported format.
  Assumes: caller registers the results; 32-bit data in memIn[31:0].
*/
`timescale 1ns/1ps
module fpf_layout_conv (
  input wire fpf_pkg::fpf_fmt_t fmt,
  input wire logic [fpf_pkg::DATA_W-1:0] memIn,
  input wire logic [fpf_pkg::DATA_W-1:0] regIn,
  output logic [fpf_pkg::DATA_W-1:0] ldReg,
  output logic [fpf_pkg::DATA_W-1:0] stMem
);
  import fpf_pkg::*;

  function automatic logic [63:0] swapHalves(input logic [63:0] d);
    swapHalves = {d[15:0], d[31:16], d[47:32], d[63:48]};
  endfunction

  function automatic logic [10:0] widenExp(input logic [7:0] e, input logic ieee);
    logic [10:0] w;
    w = 11'h000;
    if (ieee && e == EXPN_ONES) begin
      w = EXP_ONES; // [RQ11]
    end else if (e[7]) begin
      w = {1'b1, WIDEN_HI, e[6:0]}; // [RQ11] [RQ22]
    end else if (e != 8'h00) begin
      w = {1'b0, WIDEN_LO, e[6:0]};
    end
    widenExp = w;
  endfunction

  always_comb begin
    ldReg = ZERO64;
    stMem = ZERO64;
    case (fmt)
      FMT_F: begin
        ldReg = {memIn[15], widenExp(memIn[14:7], 1'b0), memIn[6:0], memIn[31:16],
                 29'h0000_0000}; // [RQ22]
        stMem = {32'h0000_0000, regIn[44:29], regIn[63], regIn[62], regIn[58:52],
                 regIn[51:45]};
      end
      FMT_G, FMT_D: begin
        ldReg = swapHalves(memIn); // [RQ1] [RQ2] [RQ7] [RQ8]
        stMem = swapHalves(regIn); // [RQ7]
      end
      FMT_S: begin
        ldReg = {memIn[31], widenExp(memIn[30:23], 1'b1), memIn[22:0],
                 29'h0000_0000}; // [RQ10] [RQ13] [RQ14]
        stMem = {32'h0000_0000, regIn[63], regIn[62], regIn[58:52],
                 regIn[51:29]}; // [RQ12]
      end
      FMT_T: begin
        ldReg = memIn; // [RQ16]
        stMem = regIn; // [RQ16]
      end
      default: begin
        ldReg = ZERO64;
        stMem = ZERO64;
      end
    endcase
  end

endmodule

/* File: verilog/fpf_classify.sv */
/*
  fpf_classify: combinational classification of one register-format
  operand and its unbiased exponent.
  Assumes: single-precision IEEE operands are already in double form.
*/
`timescale 1ns/1ps
module fpf_classify (
  input wire fpf_pkg::fpf_fmt_t fmt,
  input wire logic [fpf_pkg::DATA_W-1:0] opnd,
  output logic isZero,
  output logic isResv,
  output logic isNan,
  output logic isSnan,
  output logic isInf,
  output logic isDenorm,
  output logic [fpf_pkg::TEXP_W-1:0] trueExp
);
  import fpf_pkg::*;

  logic [10:0] expCode;
  logic [7:0] expNarrow;
  logic sgn;
  logic fracNz;

  always_comb begin
    expCode = opnd[EXP_MSB:EXP_LSB];
    expNarrow = opnd[EXP_MSB:D_EXP_LSB];
    sgn = opnd[SIGN_POS];
    fracNz = opnd[FRAC_MSB:0] != 52'h0_0000_0000_0000;
    isZero = 1'b0;
    isResv = 1'b0;
    isNan = 1'b0;
    isSnan = 1'b0;
    isInf = 1'b0;
    isDenorm = 1'b0;
    trueExp = 12'h000;
    if (fmt == FMT_D) begin
      if (expNarrow == 8'h00) begin
        isZero = !sgn; // [RQ3] [RQ8]
        isResv = sgn; // [RQ5]
      end else begin
        trueExp = 12'(expNarrow) - D_BIAS; // [RQ8]
      end
    end else if (isLegacy(fmt)) begin
      if (expCode == 11'h000) begin
        isZero = !sgn; // [RQ3]
        isResv = sgn; // [RQ5]
      end else begin
        trueExp = 12'(expCode) - G_BIAS; // [RQ6]
      end
    end else if (expCode == EXP_ONES) begin
      isNan = fracNz; // [RQ15] [RQ18]
      isSnan = fracNz && !opnd[QUIET_POS]; // [RQ20]
      isInf = !fracNz;
    end else if (expCode == 11'h000) begin
      isZero = !fracNz;
      isDenorm = fracNz; // [RQ15] [RQ18]
      trueExp = (fmt == FMT_S) ? S_DEN_EXP : T_DEN_EXP;
    end else begin
      trueExp = 12'(expCode) - T_BIAS; // [RQ14] [RQ17]
    end
  end

endmodule

/* File: verilog/fpf_ldst_unit.sv */
/*
  fpf_ldst_unit: floating-point load/store format converter with operand
  classification, exception causes, ordered compare and zero cleanup of
  legacy results. Conversions are combinational and registered once.
  Assumes: load/store path, register file and arithmetic units drive
  the strobes synchronously to clk; no buffering.
*/
// Operation
// RQ1 - wide legacy double: sign, exponent, fraction fields
// RQ2 - wide legacy fraction halfword significance order
// RQ3 - legacy exponent zero, sign zero is zero
// RQ4 - legacy zero result is all zeros
// RQ5 - legacy reserved operand raises arithmetic exception
// RQ6 - wide legacy codes map to exponents +-1023
// RQ7 - narrow legacy double reorders like wide
// RQ8 - narrow legacy double follows legacy single conventions
// RQ9 - no narrow legacy double arithmetic
// RQ10 - single load widens exponent, zeros low fraction
// RQ11 - single load exponent mapping table
// RQ12 - single store drops bits, no checking
// RQ13 - single load does not validate input
// RQ14 - single memory fields: sign, exponent, fraction
// RQ15 - classify single NaN, infinity, denormal, zero
// RQ16 - double load/store moves bits unchanged
// RQ17 - double fields: sign, exponent, fraction
// RQ18 - classify double NaN, infinity, denormal
// RQ19 - IEEE arithmetic traps raise exception
// RQ20 - signaling NaN invalid, quiet NaN silent
// RQ21 - infinities order beyond every finite value
// RQ22 - legacy single all-ones exponent maps ordinarily
// RQ23 - conversion combinational within transfer cycle
`timescale 1ns/1ps
module fpf_ldst_unit (
  input wire logic clk,
  input wire logic sys_rst,
  input wire fpf_pkg::fpf_fmt_t fmt,
  input wire logic ldValid,
  input wire logic [fpf_pkg::DATA_W-1:0] memData,
  input wire logic stValid,
  input wire logic [fpf_pkg::DATA_W-1:0] regData,
  input wire logic opValid,
  input wire logic [fpf_pkg::TRAP_W-1:0] ieeeTrap,
  input wire logic cmpValid,
  input wire logic [fpf_pkg::DATA_W-1:0] regDataB,
  input wire logic resValid,
  input wire logic [fpf_pkg::DATA_W-1:0] resData,
  output logic ldDone,
  output logic [fpf_pkg::DATA_W-1:0] ldData,
  output logic stDone,
  output logic [fpf_pkg::DATA_W-1:0] stData,
  output logic clsDone,
  output logic clsZero,
  output logic clsReserved,
  output logic clsNan,
  output logic clsSnan,
  output logic clsInf,
  output logic clsDenorm,
  output logic [fpf_pkg::TEXP_W-1:0] clsExp,
  output logic opExc,
  output logic [fpf_pkg::CAUSE_W-1:0] opCause,
  output logic cmpDone,
  output logic cmpLess,
  output logic cmpUnordered,
  output logic resDone,
  output logic [fpf_pkg::DATA_W-1:0] resOut
);
  import fpf_pkg::*;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  function automatic logic [64:0] orderKey(input logic [63:0] v);
    orderKey = v[63] ? {1'b0, ~v} : {1'b1, v};
  endfunction

  logic [63:0] ldConv;
  logic [63:0] stConv;
  logic aZero, aResv, aNan, aSnan, aInf, aDen;
  logic bZero, bResv, bNan;
  logic rZero, rResv;
  logic [11:0] aExp;
  logic [7:0] causeVec;

  fpf_layout_conv uConv (
    .fmt(fmt),
    .memIn(memData),
    .regIn(regData),
    .ldReg(ldConv),
    .stMem(stConv)
  );

  fpf_classify uClsA (
    .fmt(fmt),
    .opnd(regData),
    .isZero(aZero),
    .isResv(aResv),
    .isNan(aNan),
    .isSnan(aSnan),
    .isInf(aInf),
    .isDenorm(aDen),
    .trueExp(aExp)
  );

  fpf_classify uClsB (
    .fmt(fmt),
    .opnd(regDataB),
    .isZero(bZero),
    .isResv(bResv),
    .isNan(bNan),
    .isSnan(),
    .isInf(),
    .isDenorm(),
    .trueExp()
  );

  fpf_classify uClsR (
    .fmt(fmt),
    .opnd(resData),
    .isZero(rZero),
    .isResv(rResv),
    .isNan(),
    .isSnan(),
    .isInf(),
    .isDenorm(),
    .trueExp()
  );

  logic ldDone_reg, ldDone_next;
  logic [63:0] ldData_reg, ldData_next;
  logic stDone_reg, stDone_next;
  logic [63:0] stData_reg, stData_next;
  logic clsDone_reg, clsDone_next;
  logic [5:0] clsFlags_reg, clsFlags_next;
  logic [11:0] clsExp_reg, clsExp_next;
  logic opExc_reg, opExc_next;
  logic [6:0] opCause_reg, opCause_next;
  logic cmpDone_reg, cmpDone_next;
  logic cmpLess_reg, cmpLess_next;
  logic cmpUnord_reg, cmpUnord_next;
  logic resDone_reg, resDone_next;
  logic [63:0] resOut_reg, resOut_next;

  always_comb begin
    causeVec = 8'h00;
    ldDone_next = ldValid; // [RQ23]
    ldData_next = ldValid ? ldConv : ldData_reg;
    stDone_next = stValid; // [RQ23]
    stData_next = stValid ? stConv : stData_reg;
    clsDone_next = opValid || cmpValid;
    clsFlags_next = clsFlags_reg;
    clsExp_next = clsExp_reg;
    if (opValid || cmpValid) begin
      clsFlags_next = {aDen, aInf, aSnan, aNan, aResv, aZero}; // [RQ15] [RQ18]
      clsExp_next = aExp; // [RQ6]
    end
    if (opValid) begin
      causeVec[CS_RESERVED] = aResv; // [RQ5]
      causeVec[CS_NO_ARITH] = (fmt == FMT_D); // [RQ9]
      if (!isLegacy(fmt)) begin
        causeVec[4:0] = ieeeTrap; // [RQ19]
        causeVec[CS_INVALID] = ieeeTrap[CS_INVALID] || aSnan; // [RQ20]
      end
    end
    opCause_next = causeVec[6:0];
    opExc_next = causeVec != 8'h00; // [RQ5] [RQ19] [RQ20]
    cmpDone_next = cmpValid;
    cmpLess_next = cmpLess_reg;
    cmpUnord_next = cmpUnord_reg;
    if (cmpValid) begin
      cmpUnord_next = aNan || bNan || aResv || bResv;
      cmpLess_next = !(aNan || bNan || aResv || bResv) && !(aZero && bZero)
                     && (orderKey(regData) < orderKey(regDataB)); // [RQ21]
    end
    resDone_next = resValid;
    resOut_next = resOut_reg;
    if (resValid) begin
      resOut_next = (isLegacy(fmt) && (rZero || rResv)) ? ZERO64 : resData; // [RQ4]
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ldDone_reg <= 1'b0;
      ldData_reg <= ZERO64;
      stDone_reg <= 1'b0;
      stData_reg <= ZERO64;
      clsDone_reg <= 1'b0;
      clsFlags_reg <= 6'h00;
      clsExp_reg <= 12'h000;
      opExc_reg <= 1'b0;
      opCause_reg <= 7'h00;
      cmpDone_reg <= 1'b0;
      cmpLess_reg <= 1'b0;
      cmpUnord_reg <= 1'b0;
      resDone_reg <= 1'b0;
      resOut_reg <= ZERO64;
    end else begin
      ldDone_reg <= ldDone_next;
      ldData_reg <= ldData_next;
      stDone_reg <= stDone_next;
      stData_reg <= stData_next;
      clsDone_reg <= clsDone_next;
      clsFlags_reg <= clsFlags_next;
      clsExp_reg <= clsExp_next;
      opExc_reg <= opExc_next;
      opCause_reg <= opCause_next;
      cmpDone_reg <= cmpDone_next;
      cmpLess_reg <= cmpLess_next;
      cmpUnord_reg <= cmpUnord_next;
      resDone_reg <= resDone_next;
      resOut_reg <= resOut_next;
    end
  end

  assign ldDone = ldDone_reg;
  assign ldData = ldData_reg;
  assign stDone = stDone_reg;
  assign stData = stData_reg;
  assign clsDone = clsDone_reg;
  assign clsZero = clsFlags_reg[0];
  assign clsReserved = clsFlags_reg[1];
  assign clsNan = clsFlags_reg[2];
  assign clsSnan = clsFlags_reg[3];
  assign clsInf = clsFlags_reg[4];
  assign clsDenorm = clsFlags_reg[5];
  assign clsExp = clsExp_reg;
  assign opExc = opExc_reg;
  assign opCause = opCause_reg;
  assign cmpDone = cmpDone_reg;
  assign cmpLess = cmpLess_reg;
  assign cmpUnordered = cmpUnord_reg;
  assign resDone = resDone_reg;
  assign resOut = resOut_reg;

  // checking helpers: inputs one cycle back
  logic [63:0] memPrev;
  logic [63:0] regPrev;
  logic [63:0] regBPrev;
  fpf_fmt_t fmtPrev;

  always_ff @(posedge clk) begin
    memPrev <= memData;
    regPrev <= regData;
    regBPrev <= regDataB;
    fmtPrev <= fmt;
  end

  AST_G_ORDER: assert property ( // [RQ2]
    ldDone && fmtPrev == FMT_G |-> ldData ==
      {memPrev[15:0], memPrev[31:16], memPrev[47:32], memPrev[63:48]})
    else $error("wide legacy load order wrong");

  AST_D_SAME: assert property ( // [RQ7]
    stDone && fmtPrev == FMT_D |-> stData ==
      {regPrev[15:0], regPrev[31:16], regPrev[47:32], regPrev[63:48]})
    else $error("narrow legacy store order differs");

  AST_S_EXP_ONES: assert property ( // [RQ11]
    ldDone && fmtPrev == FMT_S && memPrev[30:23] == 8'hFF |->
      ldData[62:52] == EXP_ONES && ldData[28:0] == 29'h0000_0000)
    else $error("single load all-ones exponent wrong");

  AST_S_EXP_LOW: assert property ( // [RQ10]
    ldDone && fmtPrev == FMT_S && !memPrev[30] && memPrev[29:23] != 7'h00 |->
      ldData[62:52] == {4'h7, memPrev[29:23]})
    else $error("single load exponent widening wrong");

  AST_F_EXP_ONES: assert property ( // [RQ22]
    ldDone && fmtPrev == FMT_F && memPrev[14:7] == 8'hFF |->
      ldData[62:52] == F_ONES_MAP)
    else $error("legacy single all-ones mapping wrong");

  AST_S_STORE: assert property ( // [RQ12]
    stDone && fmtPrev == FMT_S |->
      stData == {32'h0000_0000, regPrev[63:62], regPrev[58:29]})
    else $error("single store layout wrong");

  AST_T_PASS: assert property ( // [RQ16]
    ldValid && fmt == FMT_T ##1 ldDone |-> ldData == memPrev)
    else $error("double load altered data");

  AST_LATENCY: assert property ( // [RQ23]
    stValid |=> stDone ##1 (stDone == $past(stValid)))
    else $error("store answer not one cycle later");

  AST_RESV_EXC: assert property ( // [RQ5]
    opValid && isLegacy(fmt) && regData[63] && regData[62:52] == 11'h000 |=>
      opExc && opCause[CS_RESERVED])
    else $error("reserved operand did not trap");

  AST_QNAN_QUIET: assert property ( // [RQ20]
    opValid && fmt == FMT_T && regData[62:51] == 12'hFFF && ieeeTrap == 5'h00 |=>
      !opExc)
    else $error("quiet nan raised exception");

  AST_ZERO_RES: assert property ( // [RQ4]
    resValid && fmt == FMT_G && resData[62:52] == 11'h000 |=> resOut == ZERO64)
    else $error("legacy zero result not clean");

  AST_INF_CMP: assert property ( // [RQ21]
    cmpValid && fmt == FMT_T && regData == 64'hFFF0_0000_0000_0000 &&
      regDataB[62:52] != EXP_ONES |=> cmpLess && !cmpUnordered)
    else $error("negative infinity not below finite");

  COV_S_LOAD: cover property (ldDone && fmtPrev == FMT_S);
  COV_RESV: cover property (opExc && opCause[CS_RESERVED]);
  COV_CMP: cover property (cmpDone && cmpLess);
  COV_DEN: cover property (clsDone && clsDenorm);

endmodule

/* File: verif/fpf_mem_path.sv */
/*
  fpf_mem_path: model of the memory load path that feeds load data.
  Assumes: bench raises issue for one cycle, synchronous to clk.
*/
`timescale 1ns/1ps
module fpf_mem_path (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic issue,
  input wire logic [fpf_pkg::DATA_W-1:0] word,
  output logic ldValid,
  output logic [fpf_pkg::DATA_W-1:0] memData
);
  import fpf_pkg::*;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ldValid <= 1'b0;
      memData <= ZERO64;
    end else if (issue) begin
      // one datum per strobe, no checking of content
      ldValid <= 1'b1;
      memData <= word;
    end else begin
      // released bus: pattern changes every cycle
      ldValid <= 1'b0;
      memData <= ~memData;
    end
  end
endmodule

/* File: verif/testbench.sv */
/*
  testbench: self-checking bench for the load/store format converter.
  Assumes: single clock; expectations from format rules; queue scoreboard.
*/
`timescale 1ns/1ps
module testbench;
  import fpf_pkg::*;
  logic clk, sys_rst, issue, stValid, opValid, cmpValid, resValid, ldValid;
  fpf_fmt_t fmt;
  logic [63:0] word, memData, regData, regDataB, resData, ldData, stData, resOut;
  logic [4:0] ieeeTrap;
  logic [11:0] clsExp;
  logic [6:0] opCause;
  logic ldDone, stDone, clsDone, clsZero, clsReserved, clsNan, clsSnan, clsInf;
  logic clsDenorm, opExc, cmpDone, cmpLess, cmpUnordered, resDone;
  logic [63:0] ldQ[$], stQ[$], resQ[$];
  logic [25:0] clsQ[$];
  logic [1:0] cmpQ[$];
  int nFail, compares;
  fpf_fmt_t fmts[5] = '{FMT_F, FMT_G, FMT_D, FMT_S, FMT_T};
  logic [7:0] exps[6] = '{8'hFF, 8'h80, 8'hFE, 8'h7F, 8'h01, 8'h00};

  fpf_mem_path i_fpf_mem_path (.clk(clk), .sys_rst(sys_rst), .issue(issue),
    .word(word), .ldValid(ldValid), .memData(memData));
  fpf_ldst_unit i_fpf_ldst_unit (.clk(clk), .sys_rst(sys_rst), .fmt(fmt),
    .ldValid(ldValid), .memData(memData), .stValid(stValid), .regData(regData),
    .opValid(opValid), .ieeeTrap(ieeeTrap), .cmpValid(cmpValid),
    .regDataB(regDataB), .resValid(resValid), .resData(resData), .ldDone(ldDone),
    .ldData(ldData), .stDone(stDone), .stData(stData), .clsDone(clsDone),
    .clsZero(clsZero), .clsReserved(clsReserved), .clsNan(clsNan),
    .clsSnan(clsSnan), .clsInf(clsInf), .clsDenorm(clsDenorm), .clsExp(clsExp),
    .opExc(opExc), .opCause(opCause), .cmpDone(cmpDone), .cmpLess(cmpLess),
    .cmpUnordered(cmpUnordered), .resDone(resDone), .resOut(resOut));

  function automatic logic [63:0] rnd64();
    return {$urandom, $urandom};
  endfunction

  function automatic logic [10:0] wid(input logic [7:0] e, input logic ieee);
    if (ieee && e == 8'hFF) return 11'h7FF;
    if (e[7]) return {4'h8, e[6:0]};
    if (e != 8'h00) return {4'h7, e[6:0]};
    return 11'h000;
  endfunction

  function automatic logic [63:0] swp(input logic [63:0] m);
    return {m[15:0], m[31:16], m[47:32], m[63:48]};
  endfunction

  function automatic logic [63:0] ldExp(input fpf_fmt_t f, input logic [63:0] m);
    case (f)
      FMT_F: return {m[15], wid(m[14:7], 1'b0), m[6:0], m[31:16], 29'h0};
      FMT_S: return {m[31], wid(m[30:23], 1'b1), m[22:0], 29'h0};
      FMT_T: return m;
      default: return swp(m);
    endcase
  endfunction

  function automatic logic [63:0] stExp(input fpf_fmt_t f, input logic [63:0] r);
    case (f)
      FMT_F: return {32'h0, r[44:29], r[63:62], r[58:52], r[51:45]};
      FMT_S: return {32'h0, r[63:62], r[58:52], r[51:29]};
      FMT_T: return r;
      default: return swp(r);
    endcase
  endfunction

  function automatic logic [25:0] clsE(input fpf_fmt_t f, input logic [63:0] r,
      input logic op, input logic [4:0] tr);
    logic [11:0] e, x;
    logic z, rv, nn, sn, inf, dn, ie, fz;
    logic [6:0] c;
    ie = (f == FMT_S) || (f == FMT_T);
    e = (f == FMT_D) ? {4'h0, r[62:55]} : {1'b0, r[62:52]};
    fz = r[51:0] == 52'h0;
    nn = ie && e == 12'h7FF && !fz;
    sn = nn && !r[51];
    inf = ie && e == 12'h7FF && fz;
    dn = ie && e == 12'h000 && !fz;
    z = ie ? (e == 12'h000 && fz) : (e == 12'h000 && !r[63]);
    rv = !ie && e == 12'h000 && r[63];
    if (ie && e == 12'h7FF) x = 12'h000;
    else if (ie) x = (e == 12'h000) ? ((f == FMT_S) ? 12'hF82 : 12'hC02) : e - 12'h3FF;
    else x = (e == 12'h000) ? 12'h000 : e - ((f == FMT_D) ? 12'h080 : 12'h400);
    c = {rv, f == FMT_D, ie ? (tr | {sn, 4'h0}) : 5'h00};
    if (!op) c = 7'h00;
    return {z, rv, nn, sn, inf, dn, x, |c, c};
  endfunction

  function automatic logic [1:0] cmpE(input logic [63:0] a, input logic [63:0] b);
    logic signed [64:0] ka, kb;
    logic un;
    ka = a[63] ? -$signed({2'b00, a[62:0]}) : $signed({2'b00, a[62:0]});
    kb = b[63] ? -$signed({2'b00, b[62:0]}) : $signed({2'b00, b[62:0]});
    un = (a[62:52] == 11'h7FF && a[51:0] != 52'h0) || (b[62:52] == 11'h7FF && b[51:0] != 52'h0);
    return {un, !un && ka < kb};
  endfunction

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      nFail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic load(input fpf_fmt_t f, input logic [63:0] m);
    @(posedge clk);
    fmt <= f;
    issue <= 1'b1;
    word <= m;
    ldQ.push_back(ldExp(f, m));
    @(posedge clk);
    issue <= 1'b0;
    @(posedge clk);
  endtask

  // k: 8 store, 4 arithmetic consume, 2 compare, 1 result
  task automatic op(input logic [3:0] k, input fpf_fmt_t f, input logic [63:0] a,
      input logic [63:0] b, input logic [4:0] tr);
    @(posedge clk);
    fmt <= f;
    regData <= a;
    regDataB <= b;
    resData <= a;
    ieeeTrap <= tr;
    {stValid, opValid, cmpValid, resValid} <= k;
    if (k[3]) stQ.push_back(stExp(f, a));
    if (k[2]) clsQ.push_back(clsE(f, a, 1'b1, tr));
    if (k[1]) clsQ.push_back(clsE(f, a, 1'b0, tr));
    if (k[1]) cmpQ.push_back(cmpE(a, b));
    if (k[0]) resQ.push_back((!f[3] && !f[4] &&
      (f[2] ? a[62:55] == 8'h00 : a[62:52] == 11'h000)) ? 64'h0 : a);
    @(posedge clk);
    {stValid, opValid, cmpValid, resValid} <= 4'h0;
  endtask

  always @(negedge clk) begin
    if (ldDone === 1'b1) chk("ldData", ldQ.size() ? ldQ.pop_front() : 'x, ldData);
    if (stDone === 1'b1) chk("stData", stQ.size() ? stQ.pop_front() : 'x, stData);
    if (resDone === 1'b1) chk("resOut", resQ.size() ? resQ.pop_front() : 'x, resOut);
    if (cmpDone === 1'b1) chk("cmp", cmpQ.size() ? cmpQ.pop_front() : 'x,
      {cmpUnordered, cmpLess});
    if (clsDone === 1'b1) chk("cls", clsQ.size() ? clsQ.pop_front() : 'x,
      {clsZero, clsReserved, clsNan, clsSnan, clsInf, clsDenorm, clsExp, opExc, opCause});
  end

  task automatic conclude;
    if (ldQ.size() + stQ.size() + clsQ.size() + cmpQ.size() + resQ.size() != 0) nFail++;
    if (nFail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    nFail++;
    conclude;
  end

  initial begin
    {sys_rst, issue, stValid, opValid, cmpValid, resValid} = 6'h20;
    {word, regData, regDataB, resData} = '0;
    ieeeTrap = 5'h00;
    fmt = FMT_T;
    void'($urandom(24419));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (fmts[i]) for (int n = 0; n < 6; n++) begin
      load(fmts[i], rnd64());
      op(4'h8, fmts[i], rnd64(), 64'h0, 5'h00);
    end
    foreach (exps[i]) begin
      load(FMT_S, {$urandom, 1'b1, exps[i], 23'h05A5});
      load(FMT_F, {$urandom, 16'h1234, 1'b0, exps[i], 7'h2A});
    end
    op(4'h4, FMT_G, {12'h000, 52'h1_2345}, 64'h0, 5'h00);
    op(4'h4, FMT_G, {12'h800, 52'h1_2345}, 64'h0, 5'h00);
    op(4'h4, FMT_G, {12'h001, 52'h0}, 64'h0, 5'h00);
    op(4'h4, FMT_G, {12'hFFF, 52'h7}, 64'h0, 5'h00);
    op(4'h4, FMT_D, {12'h008, 52'h9}, 64'h0, 5'h00);
    op(4'h4, FMT_D, {12'h800, 52'h9}, 64'h0, 5'h00);
    op(4'h4, FMT_T, {12'h7FF, 52'h8_0000_0000_0001}, 64'h0, 5'h00);
    op(4'h4, FMT_T, {12'hFFF, 52'h1}, 64'h0, 5'h00);
    op(4'h4, FMT_T, {12'h7FF, 52'h0}, 64'h0, 5'h00);
    op(4'h4, FMT_T, {12'h000, 52'h3}, 64'h0, 5'h00);
    op(4'h4, FMT_T, {12'h800, 52'h0}, 64'h0, 5'h00);
    op(4'h4, FMT_S, {12'h000, 52'h2000_0000}, 64'h0, 5'h00);
    op(4'h4, FMT_S, {12'hFFF, 52'h0}, 64'h0, 5'h00);
    for (int n = 0; n < 5; n++) op(4'h4, FMT_T, rnd64(), 64'h0, 5'h01 << n);
    op(4'h2, FMT_T, {12'hFFF, 52'h0}, 64'h8000_0000_0000_0000, 5'h00);
    op(4'h2, FMT_T, rnd64() & 64'hBFFF_FFFF_FFFF_FFFF, {12'h7FF, 52'h0}, 5'h00);
    op(4'h2, FMT_T, 64'h8000_0000_0000_0000, 64'h0, 5'h00);
    op(4'h2, FMT_T, {12'h7FF, 52'h5}, 64'h0, 5'h00);
    for (int n = 0; n < 10; n++) op(4'h2, FMT_T, rnd64() & 64'hBFFF_FFFF_FFFF_FFFF,
      rnd64() & 64'hBFFF_FFFF_FFFF_FFFF, 5'h00);
    op(4'h1, FMT_G, {12'h800, 52'h123}, 64'h0, 5'h00);
    op(4'h1, FMT_F, {12'h800, 52'h4}, 64'h0, 5'h00);
    op(4'h1, FMT_D, {12'h800, 52'h5}, 64'h0, 5'h00);
    op(4'h1, FMT_T, {12'h800, 52'h6}, 64'h0, 5'h00);
    op(4'h1, FMT_G, rnd64() | 64'h0010_0000_0000_0000, 64'h0, 5'h00);
    repeat (4) @(posedge clk);
    conclude;
  end
endmodule
